// ==== core/otp_program_mode_unlock.v ====
/*
 programming-mode unlock detector. an eight-byte key, captured on the
 crystal-input strobe, moves the part from run mode to programming mode.
 assumes rst is the power-on reset and that clk runs well faster than the
 strobe; all pin inputs are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "unlock_regs.vh"

module otp_program_mode_unlock #(
   parameter [1:0] VARIANT = 2'h3
) (
   // clock and power-on reset
   input  wire        clk,
   input  wire        rst,
   // pins from the programmer
   input  wire        crystal_input_strobe,
   input  wire [7:0]  program_data_bus,
   input  wire        program_mode_select,
   input  wire        internal_reset,
   input  wire        mode_group_select,
   // state out
   output reg         program_mode,
   output reg         array_mode,
   output reg         option_mode,
   output reg         program_enable,
   output reg  [3:0]  key_progress,
   output reg  [7:0]  key_data,
   output reg  [11:0] last_address
);

   localparam ST_IDLE = 2'h0;
   localparam ST_HIGH = 2'h1;
   localparam ST_OPEN = 2'h2;

   // key byte at each position
   function [7:0] key_at;
      input [2:0] idx;
      begin
         case (idx)
            3'h0: key_at = `KEY_BYTE_0;
            3'h1: key_at = `KEY_BYTE_1;
            3'h2: key_at = `KEY_BYTE_2;
            3'h3: key_at = `KEY_BYTE_3;
            3'h4: key_at = `KEY_BYTE_4;
            3'h5: key_at = `KEY_BYTE_5;
            3'h6: key_at = `KEY_BYTE_6;
            default: key_at = `KEY_BYTE_7;
         endcase
      end
   endfunction

   function [11:0] last_for;
      input [1:0] v;
      begin
         case (v)
            2'h0: last_for = `LAST_ADDR_0;
            2'h1: last_for = `LAST_ADDR_1;
            2'h2: last_for = `LAST_ADDR_2;
            default: last_for = `LAST_ADDR_3;
         endcase
      end
   endfunction

   wire       strobe_level;
   wire       strobe_rise;
   wire       strobe_fall;

   strobe_sync u_strobe_sync (
      .clk       (clk),
      .rst       (rst),
      .strobe_in (crystal_input_strobe),
      .level     (strobe_level),
      .rise      (strobe_rise),
      .fall      (strobe_fall)
   );

   // data and control pins; two flops each, data compared with the key only at the strobe
   // rise, when it has been stable for a microsecond already
   reg [7:0]  data_meta_reg;
   reg [7:0]  data_reg;
   reg [2:0]  ctl_meta_reg;
   reg [2:0]  ctl_reg;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         data_meta_reg <= 8'h00;
         data_reg      <= 8'h00;
         ctl_meta_reg  <= 3'h1;
         ctl_reg       <= 3'h1;
      end else begin
         data_meta_reg <= program_data_bus;
         data_reg      <= data_meta_reg;
         ctl_meta_reg  <= {mode_group_select, program_mode_select, internal_reset};
         ctl_reg       <= ctl_meta_reg;
      end
   end

   wire internal_reset_s = ctl_reg[0];
   wire epm_s    = ctl_reg[1];
   wire group_s  = ctl_reg[2];

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [3:0] count_reg;
   reg [3:0] count_next;
   reg       match_reg;
   reg       match_next;

   always @* begin
      state_next = state_reg;
      count_next = count_reg;
      match_next = match_reg;
      case (state_reg)
         ST_IDLE: begin
            // strobes only count while internal reset is low
            if (strobe_rise && !internal_reset_s) begin
               match_next = (data_reg == key_at(count_reg[2:0]));
               state_next = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (strobe_fall) begin
               state_next = ST_IDLE;
               if (!match_reg) begin
                  count_next = 4'h0;
               end else if (count_reg == `KEY_LEN - 4'h1) begin
                  count_next = `KEY_LEN;
                  state_next = ST_OPEN;
               end else begin
                  count_next = count_reg + 4'h1;
               end
            end
         end
         ST_OPEN: begin
            state_next = ST_OPEN;
         end
         default: begin
            state_next = ST_IDLE;
            count_next = 4'h0;
         end
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         count_reg <= 4'h0;
         match_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         match_reg <= match_next;
      end
   end

   wire open_w = (state_next == ST_OPEN);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         program_mode   <= 1'b0;
         array_mode     <= 1'b0;
         option_mode    <= 1'b0;
         program_enable <= 1'b0;
         key_progress   <= 4'h0;
         key_data       <= 8'h00;
         last_address   <= 12'h000;
      end else begin
         program_mode   <= open_w;
         // mode groups inside programming mode
         array_mode     <= open_w && (group_s == `MODE_ARRAY);
         option_mode    <= open_w && (group_s == `MODE_OPTION);
         program_enable <= open_w && !epm_s;
         key_progress   <= count_next;
         key_data       <= data_reg;
         last_address   <= last_for(VARIANT);
      end
   end

endmodule

`default_nettype wire

// ==== core/strobe_sync.v ====
/*
 two-flop synchroniser with edge detection for the crystal-input strobe.
 assumes the strobe is asynchronous to clk and far slower than it.
*/
`timescale 1ns/1ps
`default_nettype none

module strobe_sync (
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // raw pin
   input  wire       strobe_in,
   // synchronised level and edges
   output reg        level,
   output wire       rise,
   output wire       fall
);

   reg meta_reg;
   reg last_reg;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 1'b0;
         level    <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= strobe_in;
         level    <= meta_reg;
         last_reg <= level;
      end
   end

   assign rise = level & ~last_reg;
   assign fall = ~level & last_reg;

endmodule

`default_nettype wire

// ==== core/unlock_regs.vh ====
/*
 constants for the programming-mode unlock block: key bytes, memory sizes and
 timing figures. assumes nothing; definitions only.
*/
`ifndef UNLOCK_REGS_VH
`define UNLOCK_REGS_VH

`define KEY_LEN          4'h8
`define KEY_BYTE_0       8'hA5
`define KEY_BYTE_1       8'h5A
`define KEY_BYTE_2       8'hA5
`define KEY_BYTE_3       8'hF0
`define KEY_BYTE_4       8'h0F
`define KEY_BYTE_5       8'h00
`define KEY_BYTE_6       8'hF1
`define KEY_BYTE_7       8'h00

`define LAST_ADDR_0      12'h1FF
`define LAST_ADDR_1      12'h3FF
`define LAST_ADDR_2      12'h7FF
`define LAST_ADDR_3      12'hFFF

`define CLK_PERIOD_PS    8000
`define MIN_STROBE_NS    1000
`define MIN_STROBE_CYC   ((`MIN_STROBE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define POR_WAIT_MS      50

`define MODE_ARRAY       1'b0
`define MODE_OPTION      1'b1

`endif

// ==== dv/key_programmer.sv ====
/* programmer model: presents bytes on the data pins and pulses the strobe.
 assumes clk is the bench clock. */
`timescale 1ns/1ps
`default_nettype none
`include "unlock_regs.vh"
module key_programmer (
   // bench clock
   input  wire logic       clk,
   // pins to the device
   output var  logic       strobe,
   output var  logic [7:0] data
);
   // the programmer's own array address counter, cleared after entry
   logic [11:0] address;
   initial begin
      strobe = 1'b0;
      data = 8'h00;
   end
   // data settles before the rise and holds until after the fall
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      data <= b;
      repeat (`MIN_STROBE_CYC) @(posedge clk);
      strobe <= 1'b1;
      repeat (`MIN_STROBE_CYC) @(posedge clk);
      strobe <= 1'b0;
      repeat (10) @(posedge clk);
      data <= ~b; // released pins never keep the last byte
   endtask
   task automatic clear_address;
      @(posedge clk);
      address <= 12'h000;
   endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
/* bench for the unlock detector: keys, refusals and resets.
 assumes the programmer model and the checker. */
`timescale 1ns/1ps
`default_nettype none
`include "unlock_regs.vh"
module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        stb;
   logic [7:0]  dat;
   logic        sel = 1'b0;
   logic        ires = 1'b1;
   logic        grp = 1'b0;
   logic        pm, am, om, pe;
   logic [3:0]  prog;
   logic [7:0]  kd;
   logic [11:0] la;
   logic [3:0]  expq[$];
   logic [7:0]  key[8] = '{`KEY_BYTE_0, `KEY_BYTE_1, `KEY_BYTE_2, `KEY_BYTE_3,
                           `KEY_BYTE_4, `KEY_BYTE_5, `KEY_BYTE_6, `KEY_BYTE_7};
   int          errors = 0;
   int          num_checks = 0;
   always #4 clk = ~clk;
   key_programmer pm_u (.clk(clk), .strobe(stb), .data(dat));
   otp_program_mode_unlock dut_u (.clk(clk), .rst(rst), .crystal_input_strobe(stb),
      .program_data_bus(dat), .program_mode_select(sel), .internal_reset(ires),
      .mode_group_select(grp), .program_mode(pm), .array_mode(am), .option_mode(om),
      .program_enable(pe), .key_progress(prog), .key_data(kd), .last_address(la));
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic byte_out(input logic [7:0] b, input logic [3:0] e);
      expq.push_back(e);
      pm_u.send(b);
   endtask
   task automatic key_out(input int n);
      for (int i = 0; i < n; i++) byte_out(key[i], 4'(i + 1));
   endtask
   always @(negedge stb) begin
      repeat (6) @(posedge clk);
      if (expq.size() > 0) check({8'h0, prog}, {8'h0, expq.pop_front()});
   end
   always @(posedge stb) begin
      repeat (6) @(posedge clk);
      check({4'h0, kd}, {4'h0, dat});
   end
   initial begin
      void'($urandom(39));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      sel <= 1'b1;
      repeat (2) @(posedge clk);
      check(la, `LAST_ADDR_3);
      check({8'h0, pm, am, om, pe}, 12'h0);
      byte_out(`KEY_BYTE_0, 4'h0);
      ires <= 1'b0;
      key_out(2);
      byte_out({1'b0, 7'($urandom())}, 4'h0);
      key_out(7);
      check({10'h0, pm, pe}, 12'h0);
      grp <= 1'($urandom());
      byte_out(key[7], 4'h8);
      repeat (6) @(posedge clk);
      check({8'h0, pm, am, om, pe}, {8'h0, 1'b1, ~grp, grp, 1'b0});
      pm_u.clear_address();
      // select low and the other group, both legal only after entry
      sel <= 1'b0;
      grp <= ~grp;
      repeat (6) @(posedge clk);
      check({8'h0, pm, am, om, pe}, {8'h0, 1'b1, ~grp, grp, 1'b1});
      for (int i = 0; i < 3; i++) byte_out(key[i], 4'h8);
      sel <= 1'b1;
      repeat (6) @(posedge clk);
      check({10'h0, pm, pe}, 12'h2);
      // a second power-on reset, program-mode select grounded while it lasts
      rst <= 1'b1;
      sel <= 1'b0;
      @(posedge clk);
      rst <= 1'b0;
      sel <= 1'b1;
      repeat (2) @(posedge clk);
      check({7'h0, pm, prog}, 12'h0);
      key_out(8);
      check({11'h0, pm}, 12'h1);
      check(12'(expq.size()), 12'h0);
      final_report();
   end
   initial begin
      #200000;
      errors++;
      final_report();
   end
endmodule
bind otp_program_mode_unlock unlock_checker #(.VARIANT(VARIANT)) chk_u (.clk, .rst,
   .crystal_input_strobe, .program_mode, .array_mode, .option_mode, .program_enable,
   .key_progress, .last_address);
`default_nettype wire

// ==== dv/unlock_checker_assertions.sv ====
/* port assertions for the unlock detector.
 assumes it is bound to the top module with its VARIANT. */
`timescale 1ns/1ps
`default_nettype none
module unlock_checker #(
   parameter [1:0] VARIANT = 2'h3
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // watched pin and state
   input wire logic        crystal_input_strobe,
   input wire logic        program_mode,
   input wire logic        array_mode,
   input wire logic        option_mode,
   input wire logic        program_enable,
   input wire logic [3:0]  key_progress,
   input wire logic [11:0] last_address
);
   localparam logic [11:0] LAST = (12'h200 << VARIANT) - 12'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_mode_sticky: assert property (program_mode |=> program_mode)
      else $error("program mode dropped");
   a_enable_gated: assert property (program_enable |-> program_mode)
      else $error("enable outside program mode");
   a_array_group: assert property (array_mode |-> program_mode && !option_mode)
      else $error("array mode wrong");
   a_option_group: assert property (option_mode |-> program_mode)
      else $error("option mode wrong");
   a_unlock_full: assert property ($rose(program_mode) |-> key_progress == 4'h8)
      else $error("unlock before full key");
   a_progress_step: assert property (!$stable(key_progress) |->
      key_progress == $past(key_progress) + 4'h1 || key_progress == 4'h0)
      else $error("progress jumped");
   a_step_strobe: assert property (!$stable(key_progress) && key_progress != 4'h0
      |-> !crystal_input_strobe)
      else $error("progress moved with strobe high");
   a_last_addr: assert property (last_address != 12'h0 |-> last_address == LAST)
      else $error("last address wrong");
   a_entry_on_fall: assert property ($rose(program_mode) |-> !crystal_input_strobe)
      else $error("program mode entered with strobe high");
   cover property ($rose(program_mode));
   cover property (option_mode);
   cover property (program_enable && array_mode);
endmodule
`default_nettype wire
